// *** hw/sas_params.svh ***
// Offsets, field positions and timing counts of the converter sequencer.
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
// ==========================================
// Register byte offsets
`define SAS_OFF_TASK     12'h000
`define SAS_OFF_CTRL     12'h004
`define SAS_OFF_PTR      12'h008
`define SAS_OFF_LEN      12'h00c
`define SAS_OFF_STAT     12'h010
`define SAS_CH_PAGE      4'h1
// ==========================================
// Task bits, control and channel configuration fields
`define SAS_T_START      0
`define SAS_T_SAMPLE     1
`define SAS_T_STOP       2
`define SAS_T_CAL        3
`define SAS_RES_LSB      0
`define SAS_OVS_LSB      4
`define SAS_TMR_BIT      8
`define SAS_CC_LSB       16
`define SAS_GAIN_LSB     8
`define SAS_REF_BIT      12
`define SAS_ACQ_LSB      16
`define SAS_MODE_BIT     20
`define SAS_BURST_BIT    24
// ==========================================
// Acquisition times in microseconds and in clock cycles
`define SAS_CLK_MHZ      50
`define SAS_ACQ0_US      3
`define SAS_ACQ1_US      5
`define SAS_ACQ2_US      10
`define SAS_ACQ3_US      15
`define SAS_ACQ4_US      20
`define SAS_ACQ5_US      40
`define SAS_ACQ0_CYC     (`SAS_ACQ0_US * `SAS_CLK_MHZ)
`define SAS_ACQ1_CYC     (`SAS_ACQ1_US * `SAS_CLK_MHZ)
`define SAS_ACQ2_CYC     (`SAS_ACQ2_US * `SAS_CLK_MHZ)
`define SAS_ACQ3_CYC     (`SAS_ACQ3_US * `SAS_CLK_MHZ)
`define SAS_ACQ4_CYC     (`SAS_ACQ4_US * `SAS_CLK_MHZ)
`define SAS_ACQ5_CYC     (`SAS_ACQ5_US * `SAS_CLK_MHZ)
`endif

// *** hw/sas_pkg.sv ***
// Types shared by the converter sequencer and its users.
package sas_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_DMA, ST_CAL} sas_state_e;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sas_apb_req_s;
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } sas_apb_rsp_s;
   typedef struct packed {
      logic start;
      logic sample;
      logic stop;
      logic cal;
   } sas_task_s;
   typedef struct packed {
      logic       started;
      logic       end_buf;
      logic       done;
      logic       result_ready;
      logic       cal_complete;
      logic       stopped;
      logic [7:0] lim_high;
      logic [7:0] lim_low;
   } sas_evt_s;
   typedef struct packed {
      logic       sample;
      logic       convert;
      logic       cal;
      logic [2:0] ch;
      logic [3:0] pos_sel;
      logic [3:0] neg_sel;
      logic       neg_gnd;
      logic [2:0] gain;
      logic       reference_select;
   } sas_afe_out_s;
   typedef struct packed {
      logic        done;
      logic [14:0] code;
   } sas_afe_in_s;
   typedef struct packed {
      logic        req;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sas_dma_s;
   typedef struct packed {
      sas_state_e        st;
      sas_apb_rsp_s      rsp;
      sas_evt_s          evt;
      sas_afe_out_s      afe;
      sas_dma_s          dma;
      logic              running;
      logic              timer_on;
      logic [10:0]       tmr;
      logic [1:0]        res;
      logic [3:0]        ovs;
      logic              tmr_mode;
      logic [10:0]       cc;
      logic [31:0]       ptr;
      logic [14:0]       len;
      logic [7:0][3:0]   pos_sel;
      logic [7:0][3:0]   neg_sel;
      logic [7:0][31:0]  cfg;
      logic [7:0][31:0]  lim;
      logic [2:0]        ch;
      logic [10:0]       acq_cnt;
      logic [8:0]        ovs_cnt;
      logic [23:0]       acc;
      logic [15:0]       offset;
      logic [14:0]       amount;
      logic [15:0]       half;
      logic              half_v;
   } sas_state_s;
endpackage

// *** hw/sas_sequencer.sv ***
// Sequencer, scaling, packing and register slave of the SAR converter.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_sequencer (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire sas_pkg::sas_apb_req_s apb_req,
   output      sas_pkg::sas_apb_rsp_s apb_rsp,
   input  wire sas_pkg::sas_task_s    tasks,
   output      sas_pkg::sas_evt_s     events,
   output      sas_pkg::sas_afe_out_s afe_out,
   input  wire sas_pkg::sas_afe_in_s  afe_in,
   output      sas_pkg::sas_dma_s     dma_out,
   input  wire logic                  dma_ack
);
   import sas_pkg::*;

   sas_state_s s;
   sas_state_s next_s;

   // ==========================================
   // Per-channel enables and limit checks
   logic [7:0]  en;
   logic [7:0]  hit_hi;
   logic [7:0]  hit_lo;
   logic [15:0] res16;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_ch
         // A channel runs whenever its positive input is connected.
         // Zero means no source, so a cleared select parks the channel.
         assign en[gi] = (s.pos_sel[gi] != 4'h0);
         // Limits need no enable; software ignores events it does not want.
         assign hit_hi[gi] = (s.ch == 3'(gi)) &&
                             ($signed(res16) >= $signed(s.lim[gi][31:16]));
         assign hit_lo[gi] = (s.ch == 3'(gi)) &&
                             ($signed(res16) <= $signed(s.lim[gi][15:0]));
      end
   endgenerate

   // Acquisition cycles for the three-bit time code; codes above five hold the longest.
   // The longest time still fits the eleven-bit counter at this clock.
   // A faster clock would need a wider counter here.
   function automatic logic [10:0] acq_cycles(input logic [2:0] t);
      case (t)
         3'h0:    acq_cycles = 11'(`SAS_ACQ0_CYC);
         3'h1:    acq_cycles = 11'(`SAS_ACQ1_CYC);
         3'h2:    acq_cycles = 11'(`SAS_ACQ2_CYC);
         3'h3:    acq_cycles = 11'(`SAS_ACQ3_CYC);
         3'h4:    acq_cycles = 11'(`SAS_ACQ4_CYC);
         default: acq_cycles = 11'(`SAS_ACQ5_CYC);
      endcase
   endfunction

   // ==========================================
   // Channel search: lowest enabled channel, and the next one above the current.
   // Walking down from the top leaves the lowest hit in each result.
   logic [2:0] first;
   logic       first_v;
   logic [2:0] nxt;
   logic       nxt_v;
   always_comb begin
      first = 3'h0;
      first_v = 1'b0;
      nxt = 3'h0;
      nxt_v = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (en[i]) begin
            first = 3'(i);
            first_v = 1'b1;
            if (3'(i) > s.ch) begin
               nxt = 3'(i);
               nxt_v = 1'b1;
            end
         end
      end
   end

   // ==========================================
   // Accumulate, average and scale the current conversion.
   // Twenty-four bits hold 256 full-scale codes with the sign.
   logic [23:0] acc_new;
   logic [23:0] avg;
   logic [3:0]  shift;
   logic [4:0]  resbits;
   logic        diff;
   logic        last_ovs;
   always_comb begin
      diff = s.cfg[s.ch][`SAS_MODE_BIT];
      acc_new = s.acc + {{9{afe_in.code[14]}}, afe_in.code}
                - {{8{s.offset[15]}}, s.offset};
      last_ovs = (s.ovs_cnt + 9'h001) == (9'h001 << s.ovs);
      avg = $signed(acc_new) >>> s.ovs;
      case (s.res)
         2'h0:    resbits = 5'd8;
         2'h1:    resbits = 5'd10;
         2'h2:    resbits = 5'd12;
         // Fourteen bits only make sense with averaging behind them.
         default: resbits = (s.ovs != 4'h0) ? 5'd14 : 5'd12;
      endcase
      // The core code spans 2^14 per reference; m is one when differential.
      shift = 4'(5'd14 - resbits + {4'h0, diff});
      res16 = 16'($signed(avg) >>> shift);
   end

   // ==========================================
   // Register slave: decode and read mux.
   // Read data is latched in setup, so it stands still in access.
   logic        setup;
   logic        wr;
   logic        is_ch;
   logic [2:0]  ci;
   logic        hit;
   logic [31:0] rd;
   always_comb begin
      setup = apb_req.psel && !apb_req.penable;
      wr = apb_req.psel && apb_req.penable && apb_req.pwrite &&
           s.rsp.pready && !s.rsp.pslverr;
      is_ch = (apb_req.paddr[11:8] == `SAS_CH_PAGE) && !apb_req.paddr[7];
      ci = apb_req.paddr[6:4];
      hit = 1'b1;
      rd = 32'h0;
      if (is_ch) begin
         case (apb_req.paddr[3:2])
            2'h0:    rd = {28'h0, s.pos_sel[ci]};
            2'h1:    rd = {28'h0, s.neg_sel[ci]};
            2'h2:    rd = s.cfg[ci];
            default: rd = s.lim[ci];
         endcase
      end else begin
         case (apb_req.paddr)
            // Tasks are pulses, so their word reads back as zero.
            `SAS_OFF_TASK: rd = 32'h0;
            `SAS_OFF_CTRL: rd = {5'h0, s.cc, 7'h0, s.tmr_mode, s.ovs, 2'h0, s.res};
            `SAS_OFF_PTR:  rd = s.ptr;
            `SAS_OFF_LEN:  rd = {17'h0, s.len};
            `SAS_OFF_STAT: rd = {1'b0, s.amount, s.offset[15:0] == 16'h0 ? 13'h0 : 13'h1,
                                 s.timer_on, s.running, s.st != ST_IDLE};
            default:       hit = 1'b0;
         endcase
      end
   end

   // ==========================================
   // Sequencer next state.
   sas_task_s tk;
   logic      tick;
   logic      adv;
   logic      go_acq;
   logic [2:0] acq_ch;
   always_comb begin
      next_s = s;
      adv = 1'b0;
      go_acq = 1'b0;
      acq_ch = s.ch;
      next_s.evt = '0;
      next_s.afe.convert = 1'b0;
      next_s.afe.cal = 1'b0;
      next_s.rsp.pready = 1'b0;
      next_s.rsp.pslverr = 1'b0;
      // Answer one cycle after setup, so every access lasts exactly two cycles.
      if (setup) begin
         next_s.rsp.pready = 1'b1;
         next_s.rsp.prdata = rd;
         next_s.rsp.pslverr = !hit;
      end
      tk = tasks;
      if (wr && !is_ch) begin
         case (apb_req.paddr)
            // Each written bit fires its own task by name.
            `SAS_OFF_TASK: begin
               tk.start = tasks.start | apb_req.pwdata[`SAS_T_START];
               tk.sample = tasks.sample | apb_req.pwdata[`SAS_T_SAMPLE];
               tk.stop = tasks.stop | apb_req.pwdata[`SAS_T_STOP];
               tk.cal = tasks.cal | apb_req.pwdata[`SAS_T_CAL];
            end
            // A new resolution applies from the next finished result.
            `SAS_OFF_CTRL: begin
               next_s.res = apb_req.pwdata[`SAS_RES_LSB +: 2];
               next_s.ovs = apb_req.pwdata[`SAS_OVS_LSB +: 4];
               next_s.tmr_mode = apb_req.pwdata[`SAS_TMR_BIT];
               next_s.cc = apb_req.pwdata[`SAS_CC_LSB +: 11];
            end
            `SAS_OFF_PTR:  next_s.ptr = {apb_req.pwdata[31:2], 2'h0};
            `SAS_OFF_LEN:  next_s.len = apb_req.pwdata[14:0];
            default:       next_s.ptr = next_s.ptr;
         endcase
      end
      if (wr && is_ch) begin
         case (apb_req.paddr[3:2])
            2'h0:    next_s.pos_sel[ci] = apb_req.pwdata[3:0];
            2'h1:    next_s.neg_sel[ci] = apb_req.pwdata[3:0];
            2'h2:    next_s.cfg[ci] = apb_req.pwdata;
            default: next_s.lim[ci] = apb_req.pwdata;
         endcase
      end
      // Local rate timer; a tick that lands while busy is dropped.
      // Reloading on the tick makes the period the compare plus one.
      tick = s.timer_on && (s.tmr == 11'h0);
      if (s.timer_on) begin
         next_s.tmr = tick ? s.cc : s.tmr - 11'h001;
      end
      if (tk.start) begin
         next_s.running = 1'b1;
         next_s.amount = 15'h0;
         next_s.half_v = 1'b0;
         next_s.evt.started = 1'b1;
      end
      case (s.st)
         ST_IDLE: begin
            // Calibration starts only from idle so it never cuts a conversion.
            if (tk.cal) begin
               next_s.st = ST_CAL;
               next_s.afe.cal = 1'b1;
            end else if ((tk.sample || tick) && s.running && first_v) begin
               // Several enabled channels simply walk on after the first.
               go_acq = 1'b1;
               acq_ch = first;
               if (s.tmr_mode && tk.sample) begin
                  next_s.timer_on = 1'b1;
                  next_s.tmr = s.cc;
               end
            end
         end
         ST_ACQ: begin
            // The sampling capacitor stays connected for the channel's time.
            next_s.acq_cnt = s.acq_cnt - 11'h001;
            if (s.acq_cnt == 11'h001) begin
               next_s.afe.sample = 1'b0;
               next_s.afe.convert = 1'b1;
               next_s.st = ST_CONV;
            end
         end
         ST_CONV: begin
            // Only the front end's done pulse or a stop task ends a conversion.
            if (afe_in.done) begin
               next_s.evt.done = 1'b1;
               next_s.acc = acc_new;
               next_s.ovs_cnt = s.ovs_cnt + 9'h001;
               if (last_ovs) begin
                  // Events fire before the word reaches RAM.
                  next_s.evt.result_ready = 1'b1;
                  // Limits judge the finished result, never a partial sum.
                  next_s.evt.lim_high = hit_hi;
                  next_s.evt.lim_low = hit_lo;
                  next_s.acc = 24'h0;
                  next_s.ovs_cnt = 9'h0;
                  next_s.amount = s.amount + 15'h001;
                  if (!s.half_v && (s.amount + 15'h001 != s.len)) begin
                     next_s.half = res16;
                     next_s.half_v = 1'b1;
                     adv = 1'b1;
                  end else begin
                     // Odd tail: upper half left zero.
                     next_s.dma.wdata = s.half_v ? {res16, s.half} : {16'h0, res16};
                     next_s.dma.addr = s.ptr + {16'h0, s.amount[14:1], 2'h0};
                     next_s.dma.req = 1'b1;
                     next_s.half_v = 1'b0;
                     next_s.st = ST_DMA;
                  end
               end else if (s.cfg[s.ch][`SAS_BURST_BIT]) begin
                  // Burst runs every averaging pass off one task.
                  go_acq = 1'b1;
               end else begin
                  // Without burst each sample task adds one conversion.
                  next_s.st = ST_IDLE;
               end
            end
         end
         ST_DMA: begin
            // The word stands until memory takes it; a stop drops it.
            if (dma_ack) begin
               next_s.dma.req = 1'b0;
               adv = 1'b1;
            end
         end
         ST_CAL: begin
            // The code measured with shorted inputs becomes the offset.
            if (afe_in.done) begin
               next_s.offset = {afe_in.code[14], afe_in.code};
               next_s.evt.cal_complete = 1'b1;
               next_s.st = ST_IDLE;
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
      // After each result: finish the buffer, step the scan, or wait.
      // A buffer end clears running, so samples wait for a new start.
      if (adv) begin
         if (next_s.amount == s.len) begin
            next_s.evt.end_buf = 1'b1;
            next_s.running = 1'b0;
            next_s.timer_on = 1'b0;
            next_s.st = ST_IDLE;
         end else if (nxt_v) begin
            go_acq = 1'b1;
            acq_ch = nxt;
         end else begin
            next_s.st = ST_IDLE;
         end
      end
      if (go_acq) begin
         next_s.ch = acq_ch;
         next_s.st = ST_ACQ;
         next_s.acq_cnt = acq_cycles(s.cfg[acq_ch][`SAS_ACQ_LSB +: 3]);
         next_s.afe.sample = 1'b1;
         next_s.afe.ch = acq_ch;
         next_s.afe.pos_sel = s.pos_sel[acq_ch];
         // Single-ended grounds the negative input and hides its select.
         next_s.afe.neg_gnd = !s.cfg[acq_ch][`SAS_MODE_BIT];
         next_s.afe.neg_sel = s.cfg[acq_ch][`SAS_MODE_BIT] ? s.neg_sel[acq_ch] : 4'h0;
         next_s.afe.gain = s.cfg[acq_ch][`SAS_GAIN_LSB +: 3];
         next_s.afe.reference_select = s.cfg[acq_ch][`SAS_REF_BIT];
      end
      // Stop wins over state, timer, sampling and memory request, and always reports, even when idle.
      // A pending memory word is lost; the buffer keeps what was taken.
      if (tk.stop) begin
         next_s.st = ST_IDLE;
         next_s.running = 1'b0;
         next_s.timer_on = 1'b0;
         next_s.afe.sample = 1'b0;
         next_s.afe.convert = 1'b0;
         next_s.dma.req = 1'b0;
         next_s.acc = 24'h0;
         next_s.ovs_cnt = 9'h0;
         next_s.evt.stopped = 1'b1;
      end
   end

   // ==========================================
   // State register; all outputs come straight from it.
   // Reset clears every field, so each output starts low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs are plain views of registered fields.
   assign apb_rsp = s.rsp;
   assign events = s.evt;
   assign afe_out = s.afe;
   assign dma_out = s.dma;

endmodule // sas_sequencer

// *** verif/sas_afe_model.sv ***
// Analog front end and result memory standing at the sequencer's far side.
`timescale 1ns/1ps
module sas_afe_model
   import sas_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire sas_afe_out_s     afe_out,
   input  wire sas_dma_s         dma_out,
   input  wire logic             slow,
   input  wire logic [7:0][14:0] code_tab,
   input  wire logic [14:0]      cal_code,
   output      sas_afe_in_s      afe_in,
   output      logic             dma_ack
);
   int          cw;
   int          dw;
   logic        cal_p;
   logic [2:0]  chl;
   logic [31:0] ram [0:15];
   // ==========================================
   // Conversion answers and memory writes.
   // The code toggles outside answers so a stale value never looks valid.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cw <= 0;
         dw <= 0;
         cal_p <= 1'b0;
         chl <= 3'h0;
         afe_in <= '0;
         dma_ack <= 1'b0;
      end else begin
         afe_in.done <= 1'b0;
         afe_in.code <= ~afe_in.code;
         dma_ack <= 1'b0;
         if (afe_out.convert || afe_out.cal) begin
            cw <= slow ? 9 : 2;
            cal_p <= afe_out.cal;
            chl <= afe_out.ch;
         end else if (cw == 1) begin
            afe_in.done <= 1'b1;
            afe_in.code <= cal_p ? cal_code : code_tab[chl];
            cw <= 0;
         end else if (cw > 1) begin
            cw <= cw - 1;
         end
         // Memory accepts words late, after the events have gone by.
         if (dma_out.req && !dma_ack && dw == 0) begin
            dw <= slow ? 6 : 1;
         end else if (dw == 1) begin
            dma_ack <= 1'b1;
            ram[dma_out.addr[5:2]] <= dma_out.wdata;
            dw <= 0;
         end else if (dw > 1) begin
            dw <= dw - 1;
         end
      end
   end
endmodule // sas_afe_model

// *** verif/sas_sequencer_monitor.sv ***
// Concurrent checks on the ports of the converter sequencer.
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_sequencer_monitor
   import sas_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire sas_apb_req_s apb_req,
   input  wire sas_apb_rsp_s apb_rsp,
   input  wire sas_task_s    tasks,
   input  wire sas_evt_s     events,
   input  wire sas_afe_out_s afe_out,
   input  wire sas_afe_in_s  afe_in,
   input  wire sas_dma_s     dma_out,
   input  wire logic         dma_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [11:0] acq_len;
   // ==========================================
   // Counts cycles with the capacitor connected.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) acq_len <= 12'h000;
      else if (afe_out.sample) acq_len <= acq_len + 12'h001;
      else acq_len <= 12'h000;
   end
   sequence s_acq_over;
      $fell(afe_out.sample);
   endsequence
   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   // ==========================================
   // Acquisition, conversion, events, memory requests and register answers.
   a_acq_then_convert: assert property (s_acq_over |-> events.stopped ||
      (afe_out.convert && acq_len inside {`SAS_ACQ0_CYC, `SAS_ACQ1_CYC, `SAS_ACQ2_CYC,
      `SAS_ACQ3_CYC, `SAS_ACQ4_CYC, `SAS_ACQ5_CYC}))
      else $error("acquisition length or convert wrong");
   a_acq_pos_enabled: assert property ($rose(afe_out.sample) |-> afe_out.pos_sel != 4'h0)
      else $error("acquisition on disabled channel");
   a_neg_ground: assert property (afe_out.sample && afe_out.neg_gnd |-> afe_out.neg_sel == 4'h0)
      else $error("negative select used in single ended mode");
   a_done_follows: assert property (afe_in.done && !tasks.stop |=> events.done ^ events.cal_complete)
      else $error("no event after conversion");
   a_ready_with_done: assert property (events.result_ready |-> events.done)
      else $error("result ready without done");
   a_limit_with_ready: assert property (|{events.lim_high, events.lim_low} |-> events.result_ready)
      else $error("limit event without result");
   a_stop_stopped: assert property (tasks.stop |=> events.stopped)
      else $error("stop gave no stopped event");
   a_end_after_ack: assert property (events.end_buf |-> $past(dma_ack))
      else $error("buffer end before memory accepted");
   a_dma_holds: assert property (dma_out.req && !dma_ack && !tasks.stop |=> dma_out.req &&
      $stable(dma_out.addr) && $stable(dma_out.wdata))
      else $error("memory request changed before accepted");
   a_apb_answer: assert property (s_setup |=> apb_rsp.pready)
      else $error("register access not answered");
endmodule // sas_sequencer_monitor
bind sas_sequencer sas_sequencer_monitor mon (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .tasks(tasks), .events(events), .afe_out(afe_out), .afe_in(afe_in),
   .dma_out(dma_out), .dma_ack(dma_ack));

// *** verif/sas_sequencer_test.sv ***
// Self-checking testbench of the converter sequencer.
`timescale 1ns/1ps
`include "sas_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module sas_sequencer_test;
   import sas_pkg::*;
   logic             pclk, presetn, slow, dma_ack, err;
   sas_apb_req_s     apb_req;
   sas_apb_rsp_s     apb_rsp;
   sas_task_s        tasks;
   sas_evt_s         events;
   sas_afe_out_s     afe_out;
   sas_afe_in_s      afe_in;
   sas_dma_s         dma_out;
   logic [7:0][14:0] code_tab;
   logic [14:0]      cal_code;
   logic [15:0]      seed, lims, e1, e2, e3;
   logic [31:0]      rd;
   int               n_fail, checked, ends, b0, b1, cnt[6];
   sas_sequencer dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .tasks(tasks), .events(events), .afe_out(afe_out), .afe_in(afe_in), .dma_out(dma_out),
      .dma_ack(dma_ack));
   sas_afe_model far (.pclk(pclk), .presetn(presetn), .afe_out(afe_out), .dma_out(dma_out),
      .slow(slow), .code_tab(code_tab), .cal_code(cal_code), .afe_in(afe_in), .dma_ack(dma_ack));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Tally of event pulses; limit flags are kept from the last result.
   always @(posedge pclk) begin
      cnt[0] += int'(events.done);
      cnt[1] += int'(events.result_ready);
      cnt[2] += int'(events.end_buf);
      cnt[3] += int'(events.stopped);
      cnt[4] += int'(events.cal_complete);
      cnt[5] += int'(events.started);
      if (events.result_ready) lims <= {events.lim_high, events.lim_low};
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected stored result: offset removed, then scaled to the resolution.
   function automatic logic [15:0] exp_res(input logic [14:0] c, input int bits, input int m);
      logic signed [23:0] d;
      d = 24'($signed(c)) - 24'($signed(cal_code));
      return 16'(d >>> (14 - bits + m));
   endfunction
   task automatic wrap_up();
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      i = 0;
      do begin @(posedge pclk); i++; end while (apb_rsp.pready !== 1'b1 && i < 50);
      if (i >= 50) begin n_fail++; wrap_up(); end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic fire(input sas_task_s t);
      @(posedge pclk);
      tasks <= t;
      @(posedge pclk);
      tasks <= '0;
   endtask
   task automatic wait_cnt(input int k, input int t);
      for (int i = 0; i < 30000 && cnt[k] < t; i++) @(posedge pclk);
      if (cnt[k] < t) begin n_fail++; wrap_up(); end
   endtask
   task automatic chan(input logic [2:0] n, input logic [3:0] p, input logic [31:0] cfg);
      apb(1'b1, {`SAS_CH_PAGE, 1'b0, n, 4'h0}, {28'h0, p});
      apb(1'b1, {`SAS_CH_PAGE, 1'b0, n, 4'h4}, {28'h0, p ^ 4'h3});
      apb(1'b1, {`SAS_CH_PAGE, 1'b0, n, 4'h8}, cfg);
   endtask
   // Configures, starts, then one sample task; waits for nd conversions.
   task automatic go(input logic [31:0] ctrl, input logic [14:0] len, input int nd);
      apb(1'b1, `SAS_OFF_CTRL, ctrl);
      apb(1'b1, `SAS_OFF_PTR, 32'h2000_0000);
      apb(1'b1, `SAS_OFF_LEN, {17'h0, len});
      apb(1'b1, `SAS_OFF_TASK, 32'h1);
      b0 = cnt[0];
      b1 = cnt[1];
      fire(4'b0100);
      wait_cnt(0, b0 + nd);
   endtask
   initial begin
      presetn = 1'b0;
      apb_req = '0;
      tasks = '0;
      slow = 1'b0;
      seed = 16'd30;
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         code_tab[k] = seed[14:0];
      end
      cal_code = {7'h0, seed[7:0] | 8'h01};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SAS_OFF_STAT, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, `SAS_OFF_PTR, 32'h2000_0004);
      apb(1'b0, `SAS_OFF_PTR, 32'h0);
      `CHK(rd, 32'h2000_0004)
      apb(1'b0, 12'h0f0, 32'h0);
      `CHK({err, rd}, 33'h1_0000_0000)
      fire(4'b0001);
      wait_cnt(4, 1);
      apb(1'b0, `SAS_OFF_STAT, 32'h0);
      `CHK(rd[3], 1'b1)
      // One channel, 12 bit, limits set exactly on the result.
      e1 = exp_res(code_tab[0], 12, 0);
      chan(3'h0, 4'h1, 32'h0);
      apb(1'b1, 12'h10c, {e1, e1});
      go(32'h2, 15'd1, 1);
      wait_cnt(2, ++ends);
      `CHK(far.ram[0], {16'h0, e1})
      `CHK(lims, 16'h0101)
      // Scan of channels 1, 2, 5 with an odd length; channel 2 differential.
      chan(3'h0, 4'h0, 32'h0);
      chan(3'h1, 4'h2, 32'h0);
      chan(3'h2, 4'h3, 32'h0010_0000);
      chan(3'h5, 4'h4, 32'h0005_0000);
      go(32'h1, 15'd3, 3);
      wait_cnt(2, ++ends);
      e1 = exp_res(code_tab[1], 10, 0);
      e2 = exp_res(code_tab[2], 10, 1);
      e3 = exp_res(code_tab[5], 10, 0);
      `CHK(far.ram[0], {e2, e1})
      `CHK(far.ram[1], {16'h0, e3})
      `CHK(cnt[1] - b1, 3)
      b0 = cnt[0];
      fire(4'b0100);
      repeat (400) @(posedge pclk);
      `CHK(cnt[0], b0)
      // Burst averaging of four on one channel at 14 bit, slow far side.
      chan(3'h1, 4'h0, 32'h0);
      chan(3'h2, 4'h0, 32'h0);
      chan(3'h5, 4'h0, 32'h0);
      chan(3'h3, 4'h5, 32'h0100_0000);
      slow <= 1'b1;
      go(32'h23, 15'd1, 4);
      wait_cnt(2, ++ends);
      `CHK(far.ram[0], {16'h0, exp_res(code_tab[3], 14, 0)})
      `CHK(cnt[1] - b1, 1)
      // Averaging of two by separate sample tasks.
      slow <= 1'b0;
      chan(3'h3, 4'h5, 32'h0);
      go(32'h12, 15'd1, 1);
      repeat (20) @(posedge pclk);
      `CHK(cnt[1], b1)
      fire(4'b0100);
      wait_cnt(2, ++ends);
      `CHK(cnt[1] - b1, 1)
      `CHK(far.ram[0], {16'h0, exp_res(code_tab[3], 12, 0)})
      // Local timer on one channel, then stop twice.
      go(32'h018f_0100, 15'd100, 3);
      b1 = cnt[3];
      fire(4'b0010);
      wait_cnt(3, b1 + 1);
      b0 = cnt[0];
      repeat (900) @(posedge pclk);
      `CHK(cnt[0], b0)
      fire(4'b0010);
      wait_cnt(3, b1 + 2);
      `CHK(cnt[5], 5)
      wrap_up();
   end
endmodule // sas_sequencer_test
